//--- crs_host.sv
// host model issuing single byte reads
`timescale 1ns/1ps
module crs_host (
  input  wire       clock,
  input  wire       reg_rd_valid_q,
  input  wire [7:0] reg_rd_data_q,
  output reg        reg_rd_en = 1'b0,
  output reg  [7:0] reg_rd_addr = 8'h00
);
  task rd(input [7:0] a, output [7:0] d, output ok);
    integer n;
    begin
      ok = 1'b0;
      d = 8'h00;
      reg_rd_en = 1'b1;
      reg_rd_addr = a;
      @(posedge clock);
      #1 reg_rd_en = 1'b0;
      reg_rd_addr = ~a;
      // answer stands for one cycle after the taken edge; bounded wait
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        if (reg_rd_valid_q === 1'b1) begin
          ok = 1'b1;
          d = reg_rd_data_q;
        end else begin
          @(posedge clock);
          #1;
        end
      end
      @(posedge clock);
      #1;
    end
  endtask
endmodule

//--- crs_map.vh
// register offsets, reset values and field layout of the channel statistics bank
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

`define CRS_ADDR_W             8
`define CRS_DATA_W             8
`define CRS_RESULT_W           16
`define CRS_CHAN_W             3

`define CRS_LOWEST_IN5_LO      8'h8a
`define CRS_LOWEST_IN5_HI      8'h8b
`define CRS_LOWEST_IN6_LO      8'h8c
`define CRS_LOWEST_IN6_HI      8'h8d
`define CRS_LOWEST_IN7_LO      8'h8e
`define CRS_LOWEST_IN7_HI      8'h8f
`define CRS_LOWEST_BASE        8'h8a
`define CRS_LATEST_IN0_LO      8'ha0
`define CRS_LATEST_IN0_HI      8'ha1

`define CRS_LOWEST_FIRST_CHAN  3'h5
`define CRS_LOWEST_CHAN_COUNT  3

`define CRS_LOWEST_RESET       8'hff
`define CRS_LATEST_RESET       8'h00
`define CRS_UNMAPPED_DATA      8'h00

`define CRS_LO_BYTE_MSB        7
`define CRS_LO_BYTE_LSB        0
`define CRS_HI_BYTE_MSB        15
`define CRS_HI_BYTE_LSB        8

`endif

//--- crs_min_tracker.v
// one channel's lowest-code tracker, a low and a high byte that reload on read
`timescale 1ns/1ps
`include "crs_map.vh"

module crs_min_tracker #(
  parameter RESULT_W = `CRS_RESULT_W
) (
  input  wire                clock,
  input  wire                resetn,
  input  wire                update,
  input  wire [RESULT_W-1:0] code,
  input  wire                read_lo,
  input  wire                read_hi,
  output reg  [RESULT_W-1:0] lowest_q
);

  localparam HALF_W = RESULT_W / 2;

  reg [HALF_W-1:0]   base_lo;
  reg [HALF_W-1:0]   base_hi;
  reg [RESULT_W-1:0] lowest_d;

  always @* begin
    // a read restarts the byte from all ones before the new code is compared
    base_lo = read_lo ? {HALF_W{1'b1}} : lowest_q[HALF_W-1:0];
    base_hi = read_hi ? {HALF_W{1'b1}} : lowest_q[RESULT_W-1:HALF_W];
    lowest_d = {base_hi, base_lo};
    // a conversion in the same cycle as the read still counts
    if (update && (code < {base_hi, base_lo})) begin
      lowest_d = code;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lowest_q <= {RESULT_W{1'b1}};
    end else begin
      lowest_q <= lowest_d;
    end
  end

endmodule

//--- crs_stat_regs.v
// channel result statistics bank: lowest-code trackers and latest result readback
//
// Summary of operation
// - each lowest-code pair holds the smallest code seen since it was last read.
// - reading a lowest-code byte reloads that byte with all ones.
// - lowest-code bytes for inputs 5 to 7 sit from 0x8a, low first, reset ones.
// - latest low byte shows the bottom eight bits of the newest result.
// - latest high byte shows the top eight bits of the newest result word.
// - input 0 latest bytes sit at 0xa0 and 0xa1 and reset to zero.
`timescale 1ns/1ps
`include "crs_map.vh"
//
// register map, all bytes read only:
//   0x8a  lowest code of input 5, low byte    reset 0xff, reloads on read
//   0x8b  lowest code of input 5, high byte   reset 0xff, reloads on read
//   0x8c  lowest code of input 6, low byte    reset 0xff, reloads on read
//   0x8d  lowest code of input 6, high byte   reset 0xff, reloads on read
//   0x8e  lowest code of input 7, low byte    reset 0xff, reloads on read
//   0x8f  lowest code of input 7, high byte   reset 0xff, reloads on read
//   0xa0  latest result of input 0, low byte  reset 0x00
//   0xa1  latest result of input 0, high byte reset 0x00
//   any other address reads 0x00 and has no side effect
//
// each lowest pair is one 16-bit word compared as a whole; each byte of the
// pair reloads only when that byte itself is read, so reading the low byte
// alone restarts tracking from the high byte with a low byte of all ones.
// the latest bytes show the code as delivered, high byte msb-aligned.
//
// read timing: a request taken on one edge answers on that same edge with
// valid high for one cycle; the data byte then holds until the next read.
// a conversion taken on an edge is visible to a read taken on the next edge.
// a read and a lower conversion of the same input in one cycle: the code wins.
// back-to-back reads and conversions on every cycle are both allowed.
// inputs 1 to 4 are not tracked; their conversions are ignored here.

module crs_stat_regs #(
  parameter RESULT_W   = `CRS_RESULT_W,
  parameter CHAN_W     = `CRS_CHAN_W,
  parameter ADDR_W     = `CRS_ADDR_W,
  parameter DATA_W     = `CRS_DATA_W,
  parameter NUM_LOWEST = `CRS_LOWEST_CHAN_COUNT
) (
  // clock and reset
  input  wire                clock,
  input  wire                resetn,

  // completed conversions from the converter
  input  wire                conv_valid,
  input  wire [CHAN_W-1:0]   conv_channel,
  input  wire [RESULT_W-1:0] conv_code,

  // host read port
  input  wire                reg_rd_en,
  input  wire [ADDR_W-1:0]   reg_rd_addr,
  output reg                 reg_rd_valid_q,
  output reg  [DATA_W-1:0]   reg_rd_data_q
);

  localparam [CHAN_W-1:0] LATEST_CHAN = {CHAN_W{1'b0}};
  localparam [CHAN_W-1:0] FIRST_LOW   = `CRS_LOWEST_FIRST_CHAN;
  localparam [ADDR_W-1:0] LOW_BASE    = `CRS_LOWEST_BASE;
  localparam [ADDR_W-1:0] LATEST_LO   = `CRS_LATEST_IN0_LO;
  localparam [ADDR_W-1:0] LATEST_HI   = `CRS_LATEST_IN0_HI;
  localparam [DATA_W-1:0] UNMAPPED    = `CRS_UNMAPPED_DATA;

  // latest result for input 0
  reg  [RESULT_W-1:0]        latest_q;
  reg  [RESULT_W-1:0]        latest_d;

  // per-channel tracker wiring
  wire [NUM_LOWEST*RESULT_W-1:0] lowest_flat;
  wire [NUM_LOWEST-1:0]          rd_lo_hit;
  wire [NUM_LOWEST-1:0]          rd_hi_hit;
  wire [NUM_LOWEST-1:0]          chan_update;

  // read mux
  reg  [DATA_W-1:0]          rd_data_d;
  reg                        rd_valid_d;
  integer                    k;

  // address decode of the read request
  wire                       hit_latest_lo;
  wire                       hit_latest_hi;
  wire                       hit_any_lowest;
  wire                       hit_mapped;

  // byte views of the newest input 0 result
  wire [DATA_W-1:0]          latest_lo_byte;
  wire [DATA_W-1:0]          latest_hi_byte;

  // per-channel candidates, zero unless that channel's byte is addressed
  wire [NUM_LOWEST*DATA_W-1:0] chan_rd_data;
  reg  [DATA_W-1:0]          lowest_rd_byte;

  // input 0 conversions overwrite the latest word, all other inputs leave it
  always @* begin
    latest_d = latest_q;
    if (conv_valid && (conv_channel == LATEST_CHAN)) begin
      latest_d = conv_code;
    end
  end

  // reset clears the latest word so both bytes read zero
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latest_q <= {RESULT_W{1'b0}};
    end else begin
      latest_q <= latest_d;
    end
  end

  // bottom and top byte of the newest input 0 result word
  assign latest_lo_byte = latest_q[`CRS_LO_BYTE_MSB:`CRS_LO_BYTE_LSB];
  assign latest_hi_byte = latest_q[`CRS_HI_BYTE_MSB:`CRS_HI_BYTE_LSB];

  // the two latest bytes sit at fixed addresses next to each other
  assign hit_latest_lo  = reg_rd_en && (reg_rd_addr == LATEST_LO);
  assign hit_latest_hi  = reg_rd_en && (reg_rd_addr == LATEST_HI);

  // any tracker byte addressed; each tracker sees only its own two hits
  assign hit_any_lowest = (|rd_lo_hit) || (|rd_hi_hit);

  // a miss returns the unmapped value and must not reload any tracker
  assign hit_mapped     = hit_latest_lo || hit_latest_hi || hit_any_lowest;

  // one tracker per input 5 to 7, at consecutive byte pairs from the base address
  // addresses and channel numbers follow the generate index
  genvar g;
  generate
    for (g = 0; g < NUM_LOWEST; g = g + 1) begin : g_lowest
      // sums are formed at full width, then cut to the address and channel widths
      localparam [31:0]       LO_SUM  = LOW_BASE + 2 * g;
      localparam [31:0]       HI_SUM  = LOW_BASE + 2 * g + 1;
      localparam [31:0]       CH_SUM  = FIRST_LOW + g;
      localparam [ADDR_W-1:0] LO_ADDR = LO_SUM[ADDR_W-1:0];
      localparam [ADDR_W-1:0] HI_ADDR = HI_SUM[ADDR_W-1:0];
      localparam [CHAN_W-1:0] CHAN    = CH_SUM[CHAN_W-1:0];

      // byte views of this tracker's word
      wire [RESULT_W-1:0] lowest_word;
      wire [DATA_W-1:0]   lo_byte;
      wire [DATA_W-1:0]   hi_byte;

      // low byte at the even address, high byte at the odd one
      assign rd_lo_hit[g]   = reg_rd_en && (reg_rd_addr == LO_ADDR);
      assign rd_hi_hit[g]   = reg_rd_en && (reg_rd_addr == HI_ADDR);

      // only conversions of this tracker's own input are compared
      assign chan_update[g] = conv_valid && (conv_channel == CHAN);

      // a read and a conversion of the same input may meet in one cycle
      crs_min_tracker #(
        .RESULT_W (RESULT_W)
      ) u_tracker (
        .clock    (clock),
        .resetn   (resetn),
        .update   (chan_update[g]),
        .code     (conv_code),
        .read_lo  (rd_lo_hit[g]),
        .read_hi  (rd_hi_hit[g]),
        .lowest_q (lowest_flat[g*RESULT_W +: RESULT_W])
      );

      // the stored word is read before the reload of this same read lands
      assign lowest_word = lowest_flat[g*RESULT_W +: RESULT_W];
      assign lo_byte     = lowest_word[DATA_W-1:0];
      assign hi_byte     = lowest_word[RESULT_W-1:RESULT_W-DATA_W];

      // low and high hits never meet, so the two bytes can be or-ed
      assign chan_rd_data[g*DATA_W +: DATA_W] =
        ({DATA_W{rd_lo_hit[g]}} & lo_byte) | ({DATA_W{rd_hi_hit[g]}} & hi_byte);
    end
  endgenerate

  // or of the channel candidates; only the addressed one is non-zero
  // a one-hot hit makes the or equal to a plain select
  always @* begin
    lowest_rd_byte = {DATA_W{1'b0}};
    for (k = 0; k < NUM_LOWEST; k = k + 1) begin
      lowest_rd_byte = lowest_rd_byte | chan_rd_data[k*DATA_W +: DATA_W];
    end
  end

  // read mux; idle cycles keep the last byte so the host may sample late
  // the value returned is the one held before any reload of this read
  always @* begin
    rd_valid_d = reg_rd_en;
    rd_data_d  = reg_rd_data_q;
    if (reg_rd_en) begin
      if (!hit_mapped) begin
        rd_data_d = UNMAPPED;
      end else if (hit_latest_lo) begin
        rd_data_d = latest_lo_byte;
      end else if (hit_latest_hi) begin
        rd_data_d = latest_hi_byte;
      end else begin
        rd_data_d = lowest_rd_byte;
      end
    end
  end

  // valid marks the one cycle after a request was taken
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= rd_valid_d;
    end
  end

  // the data byte reads zero out of reset, like an unmapped address
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data_q <= {DATA_W{1'b0}};
    end else begin
      reg_rd_data_q <= rd_data_d;
    end
  end

endmodule

//--- crs_stat_regs_sva.sv
// read port assertions for the statistics bank
`timescale 1ns/1ps
module crs_stat_regs_sva (
  input wire        clock,
  input wire        resetn,
  input wire        conv_valid,
  input wire [2:0]  conv_channel,
  input wire [15:0] conv_code,
  input wire        reg_rd_en,
  input wire [7:0]  reg_rd_addr,
  input wire        reg_rd_valid_q,
  input wire [7:0]  reg_rd_data_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_rel; reg_rd_en && reg_rd_addr == 8'h8a && !conv_valid ##1 !conv_valid ##1
    reg_rd_en && reg_rd_addr == 8'h8a && !conv_valid |=> reg_rd_data_q == 8'hff; endproperty
  a_rel: assert property (p_rel) else $error("no reload");
  property p_new; conv_valid && conv_channel == 3'h0 ##1 reg_rd_en && !conv_valid &&
    reg_rd_addr[7:1] == 7'h50 |=> reg_rd_data_q == ($past(reg_rd_addr[0]) ?
    $past(conv_code[15:8], 2) : $past(conv_code[7:0], 2)); endproperty
  a_new: assert property (p_new) else $error("bad latest byte");
  property p_vld; 1'b1 |=> reg_rd_valid_q == $past(reg_rd_en); endproperty
  a_vld: assert property (p_vld) else $error("valid not one cycle after read");
  property p_hold; !reg_rd_en |=> $stable(reg_rd_data_q); endproperty
  a_hold: assert property (p_hold) else $error("read data changed while idle");
  property p_unmap; reg_rd_en && reg_rd_addr != 8'ha0 && reg_rd_addr != 8'ha1 &&
    (reg_rd_addr < 8'h8a || reg_rd_addr > 8'h8f) |=> reg_rd_data_q == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_min; conv_valid && conv_channel == 3'h5 && !reg_rd_en ##1
    reg_rd_en && reg_rd_addr == 8'h8b && !conv_valid |=>
    reg_rd_data_q <= $past(conv_code[15:8], 2); endproperty
  a_min: assert property (p_min) else $error("lowest high byte above code");
endmodule

//--- crs_stat_regs_tb.sv
// self-checking bench for the statistics bank
`timescale 1ns/1ps
module crs_stat_regs_tb;
  reg         clock = 1'b0, resetn = 1'b0, conv_valid = 1'b0, ok;
  reg  [2:0]  conv_channel = 3'h0;
  reg  [15:0] conv_code = 16'h0000, lt = 16'h0000, mn [0:2];
  reg  [7:0]  d;
  wire        reg_rd_en, reg_rd_valid_q;
  wire [7:0]  reg_rd_addr, reg_rd_data_q;
  integer     seed = 22565, bad_count = 0, check_count = 0, i, k;
  initial forever #2 clock = ~clock;
  crs_stat_regs u_crs_stat_regs (.*);
  crs_host u_crs_host (.*);
  function [7:0] exp_rd(input [7:0] a);
    exp_rd = a == 8'ha0 ? lt[7:0] : a == 8'ha1 ? lt[15:8] : a < 8'h8a || a > 8'h8f ? 8'h00
      : mn[(a - 8'h8a) >> 1][a[0]*8 +: 8];
  endfunction
  task test_done;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [7:0] seen, input [7:0] want);
    check_count = check_count + 1;
    if (seen !== want) bad_count = bad_count + 1;
    if (seen !== want) $display("BAD rd_data exp %h seen %h", want, seen);
  endtask
  task rdc(input [7:0] a);
    u_crs_host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) test_done;
    chk(d, exp_rd(a));
    if (a >= 8'h8a && a <= 8'h8f) mn[(a - 8'h8a) >> 1][a[0]*8 +: 8] = 8'hff;
  endtask
  initial begin
    for (i = 0; i < 3; i = i + 1) mn[i] = 16'hffff;
    #31 resetn = 1'b1;
    for (i = -1; i < 12; i = i + 1) rdc(i < 1 ? 8'h8a : i < 10 ? 8'h8a + i : 8'h96 + i);
    for (i = 0; i < 400; i = i + 1) begin
      k = {$random(seed)} % 11;
      conv_valid = 1'b1;
      conv_channel = $random(seed);
      conv_code = $random(seed) & (16'hffff >> k);
      @(posedge clock);
      #1 conv_valid = 1'b0;
      if (conv_channel == 3'h0) lt = conv_code;
      if (conv_channel > 3'h4 && conv_code < mn[conv_channel - 3'h5])
        mn[conv_channel - 3'h5] = conv_code;
      rdc(k < 6 ? 8'h8a + k : k < 8 ? 8'h9a + k : 8'h33);
    end
    test_done;
  end
endmodule
bind crs_stat_regs crs_stat_regs_sva u_sva (.*);
